// file: verilog/sare_estimator.sv
`timescale 1ns/1ns
`default_nettype none
module sare_estimator
(
    input wire logic clock,
    input wire logic reset,
    input wire logic estimator_clear,
    input wire logic sample_strobe,
    input wire logic signed [sare_pkg::DATA_W-1:0] v_alpha,
    input wire logic signed [sare_pkg::DATA_W-1:0] v_beta,
    input wire logic signed [sare_pkg::DATA_W-1:0] i_alpha,
    input wire logic signed [sare_pkg::DATA_W-1:0] i_beta,
    input wire logic signed [sare_pkg::DATA_W-1:0] gain_f,
    input wire logic signed [sare_pkg::DATA_W-1:0] gain_g,
    input wire logic signed [sare_pkg::DATA_W-1:0] smc_gain,
    input wire logic signed [sare_pkg::DATA_W-1:0] emf_coef,
    input wire logic signed [sare_pkg::DATA_W-1:0] speed_coef,
    input wire logic [7:0] speed_count,
    input wire logic signed [sare_pkg::DATA_W-1:0] speed_scale,
    input wire logic signed [sare_pkg::DATA_W-1:0]
        offset_limit [sare_pkg::RANGES-1],
    input wire logic signed [sare_pkg::DATA_W-1:0]
        offset_slope [sare_pkg::RANGES],
    input wire logic signed [sare_pkg::DATA_W-1:0]
        offset_const [sare_pkg::RANGES],
    output logic result_valid,
    input wire logic result_ready,
    output logic [sare_pkg::DATA_W-1:0] angle_out,
    output logic signed [sare_pkg::DATA_W-1:0] speed_out,
    output logic [sare_pkg::DATA_W-1:0] angle_raw_out,
    output logic signed [sare_pkg::DATA_W-1:0] emf_alpha,
    output logic signed [sare_pkg::DATA_W-1:0] emf_beta,
    output logic busy,
    output logic sample_overrun
);
    import sare_pkg::*;

    // ******************************************************
    // Sequencer
    // ******************************************************

    sare_state_t state_q;
    sare_state_t state_d;
    logic cordic_done;
    logic last_sample;
    logic buf_ready;
    logic overrun_q;
    logic overrun_d;

    always_comb
    begin
        state_d = state_q;
        overrun_d = sample_strobe && (state_q != S_IDLE);
        if (estimator_clear)
            state_d = S_IDLE;
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (sample_strobe)
                        state_d = S_MODEL;
                end
                S_MODEL:
                    state_d = S_EMF1;
                S_EMF1:
                    state_d = S_EMF2;
                S_EMF2:
                    state_d = S_ANGLE;
                S_ANGLE:
                    state_d = S_WAIT;
                S_WAIT:
                begin
                    if (cordic_done)
                        state_d = S_SPEED;
                end
                S_SPEED:
                    state_d = last_sample ? S_SPDF : S_OFFSET;
                S_SPDF:
                    state_d = S_OFFSET;
                S_OFFSET:
                    state_d = S_PUSH;
                S_PUSH:
                begin
                    if (buf_ready)
                        state_d = S_IDLE;
                end
                default:
                    state_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= S_IDLE;
            overrun_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            overrun_q <= overrun_d;
        end
    end

    assign busy = (state_q != S_IDLE);
    assign sample_overrun = overrun_q;

    // ******************************************************
    // Sample capture
    // ******************************************************

    logic signed [DATA_W-1:0] v_q [2];
    logic signed [DATA_W-1:0] v_d [2];
    logic signed [DATA_W-1:0] i_q [2];
    logic signed [DATA_W-1:0] i_d [2];

    always_comb
    begin
        v_d = v_q;
        i_d = i_q;
        if (state_q == S_IDLE && sample_strobe)
        begin
            v_d[0] = v_alpha;
            v_d[1] = v_beta;
            i_d[0] = i_alpha;
            i_d[1] = i_beta;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            v_q <= '{default: '0};
            i_q <= '{default: '0};
        end
        else
        begin
            v_q <= v_d;
            i_q <= i_d;
        end
    end

    // ******************************************************
    // Current observer and back-EMF filters, one per axis
    // ******************************************************

    logic signed [DATA_W-1:0] emf1 [2];
    logic signed [DATA_W-1:0] emf2 [2];

    for (genvar ax = 0; ax < 2; ax++)
    begin : g_axis
        logic signed [DATA_W-1:0] i_est_q, i_est_d;
        logic signed [DATA_W-1:0] corr_q, corr_d;
        logic signed [DATA_W+1:0] drive;

        always_comb
        begin
            i_est_d = i_est_q;
            corr_d = corr_q;
            drive = '0;
            if (estimator_clear)
            begin
                i_est_d = '0;
                corr_d = '0;
            end
            else if (state_q == S_MODEL)
            begin
                // The sign alone steers the correction.
                corr_d = (i_est_q >= i_q[ax]) ? smc_gain : -smc_gain;
                drive = (DATA_W+2)'(v_q[ax]) - (DATA_W+2)'(emf1[ax])
                    - (DATA_W+2)'(corr_d);
                i_est_d = sare_sat16(
                    sare_mul(32'(gain_f), 32'(i_est_q), Q15_FRAC)
                    + sare_mul(32'(gain_g), 32'(drive), Q15_FRAC));
            end
        end

        always_ff @(posedge clock or posedge reset)
        begin
            if (reset)
            begin
                i_est_q <= '0;
                corr_q <= '0;
            end
            else
            begin
                i_est_q <= i_est_d;
                corr_q <= corr_d;
            end
        end

        sare_lowpass u_emf_first
        (
            .clock(clock),
            .reset(reset),
            .clear(estimator_clear),
            .update(state_q == S_EMF1),
            .coef(emf_coef),
            .x(corr_q),
            .y(emf1[ax])
        );

        sare_lowpass u_emf_second
        (
            .clock(clock),
            .reset(reset),
            .clear(estimator_clear),
            .update(state_q == S_EMF2),
            .coef(emf_coef),
            .x(emf1[ax]),
            .y(emf2[ax])
        );
    end

    assign emf_alpha = emf2[0];
    assign emf_beta = emf2[1];

    // ******************************************************
    // Angle
    // ******************************************************

    logic [DATA_W-1:0] angle_raw;

    sare_cordic u_cordic
    (
        .clock(clock),
        .reset(reset),
        .start(state_q == S_ANGLE),
        .x_in(emf2[0]),
        .y_in(emf2[1]),
        .angle(angle_raw),
        .done(cordic_done)
    );

    // ******************************************************
    // Speed
    // ******************************************************

    logic [DATA_W-1:0] prev_angle_q, prev_angle_d;
    logic signed [ACC_W-1:0] acc_q, acc_d;
    logic [7:0] cnt_q, cnt_d;
    logic signed [DATA_W-1:0] speed_raw_q, speed_raw_d;
    logic signed [DATA_W-1:0] delta;
    logic signed [DATA_W-1:0] speed_filt;

    // A count of zero behaves as one.
    assign last_sample = (cnt_q + 8'h01 >= speed_count);

    always_comb
    begin
        prev_angle_d = prev_angle_q;
        acc_d = acc_q;
        cnt_d = cnt_q;
        speed_raw_d = speed_raw_q;
        delta = angle_raw - prev_angle_q;
        if (estimator_clear)
        begin
            prev_angle_d = '0;
            acc_d = '0;
            cnt_d = '0;
            speed_raw_d = '0;
        end
        else if (state_q == S_SPEED)
        begin
            prev_angle_d = angle_raw;
            acc_d = acc_q + ACC_W'(delta);
            cnt_d = cnt_q + 8'h01;
            if (last_sample)
            begin
                speed_raw_d = sare_sat16(
                    sare_mul(32'(acc_d), 32'(speed_scale), Q15_FRAC));
                acc_d = '0;
                cnt_d = '0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            prev_angle_q <= '0;
            acc_q <= '0;
            cnt_q <= '0;
            speed_raw_q <= '0;
        end
        else
        begin
            prev_angle_q <= prev_angle_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            speed_raw_q <= speed_raw_d;
        end
    end

    sare_lowpass u_speed_filter
    (
        .clock(clock),
        .reset(reset),
        .clear(estimator_clear),
        .update(state_q == S_SPDF),
        .coef(speed_coef),
        .x(speed_raw_q),
        .y(speed_filt)
    );

    // ******************************************************
    // Phase compensation
    // ******************************************************

    logic signed [DATA_W-1:0] angle_offset_q, angle_offset_d;
    logic [2:0] region;

    always_comb
    begin
        region = '0;
        for (int r = 0; r < RANGES - 1; r++)
        begin
            if (speed_filt >= offset_limit[r])
                region = 3'(r + 1);
        end
        angle_offset_d = angle_offset_q;
        if (estimator_clear)
            angle_offset_d = '0;
        else if (state_q == S_OFFSET)
            angle_offset_d = sare_sat16(
                sare_mul(32'(offset_slope[region]),
                    32'(speed_filt), SLOPE_FRAC)
                + 48'(offset_const[region]));
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            angle_offset_q <= '0;
        else
            angle_offset_q <= angle_offset_d;
    end

    // ******************************************************
    // Two-entry result buffer
    // ******************************************************

    logic [WORD_W-1:0] mem_q [2];
    logic [WORD_W-1:0] mem_d [2];
    logic [1:0] fill_q, fill_d;
    logic [WORD_W-1:0] word;
    logic push;
    logic pop;
    logic wr_idx;

    assign buf_ready = (fill_q != 2'd2);
    assign push = (state_q == S_PUSH) && buf_ready;
    assign pop = result_valid && result_ready;
    assign word = {angle_raw + angle_offset_q, speed_filt, angle_raw};

    always_comb
    begin
        mem_d = mem_q;
        fill_d = fill_q;
        wr_idx = pop ? 1'b0 : fill_q[0];
        if (estimator_clear)
        begin
            // Clearing the entries also zeroes the visible speed output.
            mem_d = '{default: '0};
            fill_d = '0;
        end
        else
        begin
            if (pop)
                mem_d[0] = mem_q[1];
            if (push)
                mem_d[wr_idx] = word;
            fill_d = fill_q + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            mem_q <= '{default: '0};
            fill_q <= '0;
        end
        else
        begin
            mem_q <= mem_d;
            fill_q <= fill_d;
        end
    end

    assign result_valid = (fill_q != 2'd0);
    assign angle_out = mem_q[0][47:32];
    assign speed_out = mem_q[0][31:16];
    assign angle_raw_out = mem_q[0][15:0];
endmodule
`default_nettype wire

// file: verilog/sare_pkg.sv
package sare_pkg;
    localparam int DATA_W = 16;
    localparam int ACC_W = 24;
    localparam int WORD_W = 48;
    localparam int CORDIC_W = 19;
    localparam int CORDIC_ITER = 15;
    localparam int RANGES = 8;
    localparam int Q15_FRAC = 15;
    localparam int SLOPE_FRAC = 12;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int PWM_PERIOD_NS = 125000;
    localparam int PWM_CYCLES = PWM_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam logic [15:0] ANGLE_HALF_TURN = 16'h8000;
    localparam logic signed [47:0] Q15_MAX = 48'sh7FFF;
    localparam logic signed [47:0] Q15_MIN = -48'sh8000;
    localparam logic [15:0] OFFSET_LIMIT_DEFAULT [RANGES-1] =
        '{16'h0C00, 16'h1800, 16'h24D0, 16'h30C3, 16'h3CCD, 16'h48B4, 16'h60C5};
    localparam logic [15:0] OFFSET_SLOPE_DEFAULT [RANGES] =
        '{16'h0000, 16'h4000, 16'h2000, 16'h1000, 16'h1000, 16'h0800,
          16'h0400, 16'h0200};
    localparam logic [15:0] OFFSET_CONST_DEFAULT [RANGES] =
        '{16'h0000, 16'h3000, 16'h0000, 16'h24D0, 16'h24D0, 16'h4337,
          16'h5564, 16'h5FC8};

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_MODEL = 4'h1,
        S_EMF1 = 4'h2,
        S_EMF2 = 4'h3,
        S_ANGLE = 4'h4,
        S_WAIT = 4'h5,
        S_SPEED = 4'h6,
        S_SPDF = 4'h7,
        S_OFFSET = 4'h8,
        S_PUSH = 4'h9
    } sare_state_t;

    // Saturates a wide signed value to the Q15 range.
    function automatic logic signed [15:0] sare_sat16(
        input logic signed [47:0] v);
        if (v > Q15_MAX)
            return 16'sh7FFF;
        if (v < Q15_MIN)
            return -16'sh8000;
        return v[15:0];
    endfunction

    // Fixed-point product with an arithmetic shift back to the operand scale.
    function automatic logic signed [47:0] sare_mul(
        input logic signed [31:0] a,
        input logic signed [31:0] b,
        input int sh);
        return (48'(a) * 48'(b)) >>> sh;
    endfunction
endpackage

// file: verilog/sare_lowpass.sv
`timescale 1ns/1ns
`default_nettype none
module sare_lowpass
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clear,
    input wire logic update,
    input wire logic signed [sare_pkg::DATA_W-1:0] coef,
    input wire logic signed [sare_pkg::DATA_W-1:0] x,
    output logic signed [sare_pkg::DATA_W-1:0] y
);
    import sare_pkg::*;

    logic signed [DATA_W-1:0] y_q;
    logic signed [DATA_W-1:0] y_d;
    logic signed [DATA_W:0] diff;

    always_comb
    begin
        diff = (DATA_W+1)'(x) - (DATA_W+1)'(y_q);
        y_d = y_q;
        if (clear)
            y_d = '0;
        else if (update)
            y_d = sare_sat16(48'(y_q)
                + sare_mul(32'(coef), 32'(diff), Q15_FRAC));
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            y_q <= '0;
        else
            y_q <= y_d;
    end

    assign y = y_q;
endmodule
`default_nettype wire

// file: verilog/sare_cordic.sv
`timescale 1ns/1ns
`default_nettype none
module sare_cordic
(
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic signed [sare_pkg::DATA_W-1:0] x_in,
    input wire logic signed [sare_pkg::DATA_W-1:0] y_in,
    output logic [sare_pkg::DATA_W-1:0] angle,
    output logic done
);
    import sare_pkg::*;

    logic signed [CORDIC_W-1:0] x_q, x_d, y_q, y_d;
    logic [DATA_W-1:0] z_q, z_d;
    logic [3:0] iter_q, iter_d;
    logic run_q, run_d;
    logic done_q, done_d;

    // One angle step per iteration, in units of a full turn over 65536.
    function automatic logic [15:0] step_angle(input logic [3:0] i);
        case (i)
            4'h0: return 16'h2000;
            4'h1: return 16'h12E4;
            4'h2: return 16'h09FB;
            4'h3: return 16'h0511;
            4'h4: return 16'h028B;
            4'h5: return 16'h0146;
            4'h6: return 16'h00A3;
            4'h7: return 16'h0051;
            4'h8: return 16'h0029;
            4'h9: return 16'h0014;
            4'hA: return 16'h000A;
            4'hB: return 16'h0005;
            4'hC: return 16'h0003;
            default: return 16'h0001;
        endcase
    endfunction

    always_comb
    begin
        x_d = x_q;
        y_d = y_q;
        z_d = z_q;
        iter_d = iter_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start)
        begin
            // Fold the left half plane over by half a turn.
            x_d = x_in[DATA_W-1] ? -CORDIC_W'(x_in) : CORDIC_W'(x_in);
            y_d = x_in[DATA_W-1] ? -CORDIC_W'(y_in) : CORDIC_W'(y_in);
            z_d = x_in[DATA_W-1] ? ANGLE_HALF_TURN : '0;
            iter_d = '0;
            run_d = 1'b1;
        end
        else if (run_q)
        begin
            if (!y_q[CORDIC_W-1])
            begin
                x_d = x_q + (y_q >>> iter_q);
                y_d = y_q - (x_q >>> iter_q);
                z_d = z_q + step_angle(iter_q);
            end
            else
            begin
                x_d = x_q - (y_q >>> iter_q);
                y_d = y_q + (x_q >>> iter_q);
                z_d = z_q - step_angle(iter_q);
            end
            iter_d = iter_q + 4'h1;
            if (iter_q == 4'(CORDIC_ITER - 1))
            begin
                run_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            x_q <= '0;
            y_q <= '0;
            z_q <= '0;
            iter_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            x_q <= x_d;
            y_q <= y_d;
            z_q <= z_d;
            iter_q <= iter_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign angle = z_q;
    assign done = done_q;
endmodule
`default_nettype wire

// file: sim/sare_estimator_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sare_estimator_checker
(
    input wire logic clock,
    input wire logic reset,
    input wire logic estimator_clear,
    input wire logic sample_strobe,
    input wire logic result_valid,
    input wire logic result_ready,
    input wire logic [sare_pkg::DATA_W-1:0] angle_out,
    input wire logic signed [sare_pkg::DATA_W-1:0] speed_out,
    input wire logic [sare_pkg::DATA_W-1:0] angle_raw_out,
    input wire logic signed [sare_pkg::DATA_W-1:0] emf_alpha,
    input wire logic signed [sare_pkg::DATA_W-1:0] emf_beta,
    input wire logic busy,
    input wire logic sample_overrun
);
    import sare_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_take;
        sample_strobe && !busy && !estimator_clear;
    endsequence
    sequence s_answer;
        (!result_valid) [*8] ##[16:17] result_valid;
    endsequence
    property p_take_busy;
        s_take |=> busy;
    endproperty
    a_take_busy: assert property (p_take_busy)
        else $error("busy missing after accepted strobe");
    property p_answer;
        disable iff (reset || estimator_clear)
        s_take ##0 !result_valid |=> s_answer;
    endproperty
    a_answer: assert property (p_answer)
        else $error("result word not ready 24 or 25 cycles after strobe");
    property p_overrun;
        sample_strobe && busy && !estimator_clear |=> sample_overrun;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("strobe while busy gave no overrun pulse");
    property p_overrun_cause;
        sample_overrun |-> $past(sample_strobe && busy);
    endproperty
    a_overrun_cause: assert property (p_overrun_cause)
        else $error("overrun pulse without a strobe while busy");
    property p_head_hold;
        disable iff (reset || estimator_clear)
        result_valid && !result_ready |=> result_valid && $stable(angle_out)
            && $stable(speed_out) && $stable(angle_raw_out);
    endproperty
    a_head_hold: assert property (p_head_hold)
        else $error("result word changed before it was taken");
    property p_clear;
        estimator_clear |=> !busy && !result_valid && emf_alpha == 0
            && emf_beta == 0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear left state behind");
    property p_reset_release;
        $fell(reset) |-> !busy && !result_valid && emf_alpha == 0;
    endproperty
    a_reset_release: assert property (p_reset_release)
        else $error("outputs not zero after reset");
    property p_idle_emf;
        !busy && !sample_strobe && !estimator_clear |=>
            $stable(emf_alpha) && $stable(emf_beta);
    endproperty
    a_idle_emf: assert property (p_idle_emf)
        else $error("back-EMF moved without an update");
endmodule
bind sare_estimator sare_estimator_checker u_chk
(
    .clock(clock), .reset(reset), .estimator_clear(estimator_clear),
    .sample_strobe(sample_strobe), .result_valid(result_valid),
    .result_ready(result_ready), .angle_out(angle_out),
    .speed_out(speed_out), .angle_raw_out(angle_raw_out),
    .emf_alpha(emf_alpha), .emf_beta(emf_beta), .busy(busy),
    .sample_overrun(sample_overrun)
);
`default_nettype wire

// file: sim/sare_sense_model.sv
`timescale 1ns/1ns
`default_nettype none
module sare_sense_model
#(
    parameter int PERIOD = 40
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic burst,
    input wire logic stall,
    input wire logic rotate,
    input wire logic [1:0] quad_sel,
    output logic sample_strobe,
    output logic signed [sare_pkg::DATA_W-1:0] i_alpha,
    output logic signed [sare_pkg::DATA_W-1:0] i_beta,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [sare_pkg::DATA_W-1:0] angle_out,
    input wire logic signed [sare_pkg::DATA_W-1:0] speed_out,
    input wire logic [sare_pkg::DATA_W-1:0] angle_raw_out,
    output logic [15:0] word_angle,
    output logic [15:0] word_speed,
    output logic [15:0] word_raw,
    output int word_count
);
    import sare_pkg::*;
    int cnt;
    logic [1:0] quad;
    logic [1:0] q;
    // ********
    // Currents pick the back-EMF quadrant; the stator model stays inside their swing.
    // ********
    assign q = quad + quad_sel;
    assign i_alpha = (q == 2'h1 || q == 2'h2) ? 16'sh4000 : -16'sh4000;
    assign i_beta = q[1] ? 16'sh4000 : -16'sh4000;
    always @(negedge clock or posedge reset)
    begin
        if (reset)
        begin
            cnt <= 0;
            quad <= 2'h0;
            sample_strobe <= 1'b0;
            result_ready <= 1'b0;
        end
        else
        begin
            sample_strobe <= enable && (burst || cnt == 0);
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            if (sample_strobe && rotate)
                quad <= quad + 2'h1;
            result_ready <= !stall;
        end
    end
    always @(posedge clock or posedge reset)
    begin
        if (reset)
            word_count <= 0;
        else if (result_valid && result_ready)
        begin
            word_angle <= angle_out;
            word_speed <= speed_out;
            word_raw <= angle_raw_out;
            word_count <= word_count + 1;
        end
    end
endmodule
`default_nettype wire

// file: sim/sare_estimator_test.sv
`timescale 1ns/1ns
`default_nettype none
module sare_estimator_test;
    import sare_pkg::*;
    logic clock, reset, clr, strobe, valid, ready, busy, ovr;
    logic enable, burst, stall, rotate;
    logic [1:0] qsel;
    logic [7:0] m;
    logic signed [15:0] va, vb, ia, ib, gf, gg, k, ec, sc, scale, ea, eb, spd;
    logic [15:0] ang, raw, w_ang, w_spd, w_raw;
    logic signed [15:0] lim [RANGES-1];
    logic signed [15:0] slp [RANGES];
    logic signed [15:0] cst [RANGES];
    logic [31:0] lfsr = 32'h000154D0;
    int w_cnt, n0;
    int n_mismatch = 0;
    int compares = 0;
    localparam logic [15:0] W_TAB [RANGES] = '{16'h0600, 16'h1200,
        16'h1E00, 16'h2A00, 16'h3600, 16'h4200, 16'h5400, 16'h7000};
    sare_estimator dut (.clock(clock), .reset(reset), .estimator_clear(clr),
        .sample_strobe(strobe), .v_alpha(va), .v_beta(vb), .i_alpha(ia),
        .i_beta(ib), .gain_f(gf), .gain_g(gg), .smc_gain(k), .emf_coef(ec),
        .speed_coef(sc), .speed_count(m), .speed_scale(scale),
        .offset_limit(lim), .offset_slope(slp), .offset_const(cst),
        .result_valid(valid), .result_ready(ready), .angle_out(ang),
        .speed_out(spd), .angle_raw_out(raw), .emf_alpha(ea), .emf_beta(eb),
        .busy(busy), .sample_overrun(ovr));
    sare_sense_model model (.clock(clock), .reset(reset), .enable(enable),
        .burst(burst), .stall(stall), .rotate(rotate), .quad_sel(qsel),
        .sample_strobe(strobe), .i_alpha(ia), .i_beta(ib),
        .result_valid(valid), .result_ready(ready), .angle_out(ang),
        .speed_out(spd), .angle_raw_out(raw), .word_angle(w_ang),
        .word_speed(w_spd), .word_raw(w_raw), .word_count(w_cnt));
    // ********
    // Helpers.
    // ********
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] near(input logic [15:0] a,
        input logic [15:0] b, input int tol);
        logic signed [15:0] d;
        d = a - b;
        return (d <= tol && d >= -tol) ? 16'h0001 : 16'h0000;
    endfunction
    function automatic logic [15:0] off(input logic signed [15:0] w);
        int r, v;
        r = 0;
        for (int i = 0; i < RANGES - 1; i++)
            if (w >= $signed(OFFSET_LIMIT_DEFAULT[i]))
                r++;
        v = (int'($signed(OFFSET_SLOPE_DEFAULT[r])) * int'(w)) >>> 12;
        v = v + int'($signed(OFFSET_CONST_DEFAULT[r]));
        return v[15:0];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_words(input int n);
        int t, goal;
        goal = w_cnt + n;
        t = 0;
        while (w_cnt < goal && t < 3000)
        begin
            @(negedge clock);
            t++;
        end
        chk(16'(w_cnt >= goal), 16'h0001);
    endtask
    task automatic conclude;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ********
    // Stimulus and checks.
    // ********
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(negedge clock)
    begin
        lfsr <= nxt(lfsr);
        va <= lfsr[15:0];
        vb <= lfsr[31:16];
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {reset, clr, enable, burst, stall, rotate, qsel} = 8'h80;
        // Model gains keep the estimate inside the measured current swing.
        {gf, gg, scale} = {16'sh4000, 16'sh0800, 16'sh0000};
        k = 16'sh4000;
        ec = 16'sh7FFF;
        sc = 16'sh7FFF;
        m = 8'h02;
        for (int i = 0; i < RANGES; i++)
        begin
            slp[i] = OFFSET_SLOPE_DEFAULT[i];
            cst[i] = OFFSET_CONST_DEFAULT[i];
            if (i < RANGES - 1)
                lim[i] = OFFSET_LIMIT_DEFAULT[i];
        end
        repeat (20) @(posedge clock);
        @(negedge clock);
        reset <= 1'b0;
        enable <= 1'b1;
        for (int q = 0; q < 4; q++)
        begin
            qsel <= 2'(q) ^ lfsr[1:0];
            wait_words(6);
            chk(near(w_raw, 16'h2000 + {qsel, 14'h0000}, 64), 16'h0001);
            chk({15'h0000, ea[15]}, {15'h0000, qsel == 1 || qsel == 2});
            chk(near(ea[15] ? -ea : ea, k, 512), 16'h0001);
            chk(w_ang, w_raw);
        end
        rotate <= 1'b1;
        for (int r = 0; r < RANGES; r++)
        begin
            scale <= W_TAB[r];
            wait_words(8);
            chk(near(w_spd, W_TAB[r], 24), 16'h0001);
            chk(near(w_ang - w_raw, off(W_TAB[r]), 96), 16'h0001);
        end
        rotate <= 1'b0;
        enable <= 1'b0;
        repeat (60) @(negedge clock);
        n0 = w_cnt;
        {stall, burst, enable} <= 3'h7;
        repeat (120) @(negedge clock);
        chk({15'h0000, ovr}, 16'h0001);
        {burst, enable} <= 2'h0;
        repeat (40) @(negedge clock);
        chk(16'(w_cnt - n0), 16'h0000);
        chk({15'h0000, busy}, 16'h0001);
        stall <= 1'b0;
        repeat (40) @(negedge clock);
        chk(16'(w_cnt - n0), 16'h0003);
        chk({15'h0000, busy | ovr}, 16'h0000);
        {enable, rotate} <= 2'h3;
        scale <= W_TAB[3];
        wait_words(6);
        enable <= 1'b0;
        repeat (40) @(negedge clock);
        clr <= 1'b1;
        @(negedge clock);
        clr <= 1'b0;
        @(negedge clock);
        chk(spd, 16'h0000);
        chk(ea | eb, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
